// ---- core/dou_cfg.svh ----
// constants for the data operation unit: offsets, field positions, reset values
`ifndef DOU_CFG_SVH
`define DOU_CFG_SVH
// ==========================================
// register offsets (byte addresses)
`define DOU_ADDR_W 8
`define DOU_OFF_CTRL 8'h00
`define DOU_OFF_DATA 8'h04
`define DOU_OFF_OPERAND 8'h08
`define DOU_OFF_MASK 8'h0C
`define DOU_OFF_REQ 8'h10
`define DOU_OFF_PRIO_HI 8'h14
`define DOU_OFF_PRIO_LO 8'h18
`define DOU_OFF_PERIPH 8'h1C
`define DOU_OFF_STATUS 8'h20
`define DOU_OFF_STAT_CLR 8'h24
`define DOU_OFF_STAT_EN 8'h28
// ==========================================
// control register fields
`define DOU_CTRL_MODE_LSB 0
`define DOU_CTRL_COND 2
`define DOU_CTRL_IE 4
`define DOU_CTRL_FLAG 5
`define DOU_CTRL_FLAG_CLR 6
// bit 6 of the group registers belongs to this unit
`define DOU_GROUP_BIT 6
// peripheral control fields
`define DOU_PER_CLK_EN 0
`define DOU_PER_RESET 1
// ==========================================
// reset values
`define DOU_RST_CTRL 8'h00
`define DOU_RST_DATA 16'h0000
`define DOU_RST_MASK 1'b1
`define DOU_RST_PRIO 2'h3
`define DOU_RST_PERIPH 2'h2
`endif

// ---- core/dou_pkg.sv ----
// types shared by the data operation unit
package dou_pkg;
  typedef enum logic [1:0] {
    DOU_MODE_CMP,
    DOU_MODE_ADD,
    DOU_MODE_SUB,
    DOU_MODE_BAD
  } dou_mode_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dou_bus_s;
  typedef struct packed {
    logic [15:0] data;
    logic valid;
  } dou_operand_s;
endpackage

// ---- core/dou_unit.sv ----
// data operation unit: compare / add / subtract engine with interrupt logic
// Operation
// - mask bit 0 passes the request to the servicing line, 1 blocks it
// - request flag reads 1 while a request is pending, else 0
// - two-bit priority split across two registers, 00 highest, 11 lowest
// - control interrupt-enable bit 1 lets requests out, 0 suppresses them; irq_o still fires on completion if status enable bit 0 is 1
// - mode 00 compare, 01 add, 10 subtract; 11 prohibited
// - writing 1 to flag-clear clears completion flag; 0 leaves it
// - add and subtract results replace the data-setting register value
// - software clears request flag by writing 0, before unmasking
// - peripheral reset bit 1 holds the unit in reset, 0 releases
// - unit clock supplied only while clock-enable bit is 1
//
// Added by the designer: the strobed register port and the address map.
`include "dou_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dou_unit (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire dou_pkg::dou_bus_s bus_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic service_req_o,
  output logic [1:0] priority_o
);
  import dou_pkg::*;

  // ==========================================
  // register state
  logic [1:0] mode_r;
  logic cond_r;
  logic ie_r;
  logic flag_r;
  logic [15:0] data_r;
  logic req_r;
  logic mask_r;
  logic prio_hi_r;
  logic prio_lo_r;
  logic clk_en_r;
  logic per_rst_r;
  logic [1:0] stat_r;
  logic [1:0] stat_en_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic service_r;
  logic [1:0] prio_out_r;
  dou_operand_s opnd_r;

  // ==========================================
  // address decode
  wire sel_ctrl = (bus_i.addr == `DOU_OFF_CTRL);
  wire sel_data = (bus_i.addr == `DOU_OFF_DATA);
  wire sel_opnd = (bus_i.addr == `DOU_OFF_OPERAND);
  wire sel_mask = (bus_i.addr == `DOU_OFF_MASK);
  wire sel_req = (bus_i.addr == `DOU_OFF_REQ);
  wire sel_phi = (bus_i.addr == `DOU_OFF_PRIO_HI);
  wire sel_plo = (bus_i.addr == `DOU_OFF_PRIO_LO);
  wire sel_per = (bus_i.addr == `DOU_OFF_PERIPH);
  wire sel_stat = (bus_i.addr == `DOU_OFF_STATUS);
  wire sel_sclr = (bus_i.addr == `DOU_OFF_STAT_CLR);
  wire sel_sen = (bus_i.addr == `DOU_OFF_STAT_EN);
  wire wr = bus_i.wr;
  wire [7:0] wd8 = bus_i.wdata[7:0];

  // unit runs only with clock supplied and out of peripheral reset
  // reset hold
  wire unit_rst = reset_i | per_rst_r;
  wire run = clk_en_r & ~per_rst_r;

  // ==========================================
  // operation datapath
  // mode decode
  wire mode_cmp = (mode_r == 2'(DOU_MODE_CMP));
  wire mode_add = (mode_r == 2'(DOU_MODE_ADD));
  wire mode_sub = (mode_r == 2'(DOU_MODE_SUB));
  wire [16:0] sum_w = {1'b0, data_r} + {1'b0, opnd_r.data};
  wire [16:0] diff_w = {1'b0, data_r} - {1'b0, opnd_r.data};
  // compare: cond 0 flags mismatch, cond 1 flags operand above setting
  wire cmp_hit = cond_r ? (opnd_r.data > data_r) : (opnd_r.data != data_r);
  // add flags carry out, subtract flags borrow
  // completion condition
  wire done_w = opnd_r.valid & run &
    ((mode_cmp & cmp_hit) | (mode_add & sum_w[16]) | (mode_sub & diff_w[16]));
  wire flag_clr = wr & sel_ctrl & wd8[`DOU_CTRL_FLAG_CLR];
  wire raise_req = done_w & ie_r;
  wire [1:0] event_w = {raise_req, done_w};

  // ==========================================
  // read mux
  wire [31:0] ctrl_rd = {24'h0, 1'b0, 1'b0, flag_r, ie_r, 1'b0, cond_r, mode_r};
  wire [31:0] rd_mux =
    sel_ctrl ? ctrl_rd :
    sel_data ? {16'h0, data_r} :
    sel_opnd ? {16'h0, opnd_r.data} :
    sel_mask ? (32'(mask_r) << `DOU_GROUP_BIT) :
    sel_req ? (32'(req_r) << `DOU_GROUP_BIT) :
    sel_phi ? (32'(prio_hi_r) << `DOU_GROUP_BIT) :
    sel_plo ? (32'(prio_lo_r) << `DOU_GROUP_BIT) :
    sel_per ? {30'h0, per_rst_r, clk_en_r} :
    sel_stat ? {30'h0, stat_r} :
    sel_sen ? {30'h0, stat_en_r} : 32'h0;

  // peripheral control lives outside the unit reset
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      clk_en_r <= 1'b0;
      per_rst_r <= 1'b1;
    end else if (wr & sel_per) begin
      clk_en_r <= wd8[`DOU_PER_CLK_EN];
      per_rst_r <= wd8[`DOU_PER_RESET];
    end
  end

  // control fields; prohibited mode 11 is ignored on write
  // mode write
  always_ff @(posedge core_clk_i) begin
    if (unit_rst) begin
      mode_r <= 2'h0;
      cond_r <= 1'b0;
      ie_r <= 1'b0;
    end else if (wr & sel_ctrl & clk_en_r) begin
      if (wd8[1:0] != 2'(DOU_MODE_BAD)) begin
        mode_r <= wd8[1:0];
      end
      cond_r <= wd8[`DOU_CTRL_COND];
      ie_r <= wd8[`DOU_CTRL_IE];
    end
  end

  // completion flag: set beats clear
  // flag set
  always_ff @(posedge core_clk_i) begin
    if (unit_rst) begin
      flag_r <= 1'b0;
    end else if (done_w) begin
      flag_r <= 1'b1;
    end else if (flag_clr & clk_en_r) begin
      flag_r <= 1'b0;
    end
  end

  // operand strobe, one cycle per data word
  always_ff @(posedge core_clk_i) begin
    if (unit_rst) begin
      opnd_r <= '0;
    end else begin
      opnd_r.valid <= wr & sel_opnd & clk_en_r;
      if (wr & sel_opnd & clk_en_r) begin
        opnd_r.data <= bus_i.wdata[15:0];
      end
    end
  end

  // data-setting register: software load, or operation result
  // result store
  always_ff @(posedge core_clk_i) begin
    if (unit_rst) begin
      data_r <= `DOU_RST_DATA;
    end else if (opnd_r.valid & run & mode_add) begin
      data_r <= sum_w[15:0];
    end else if (opnd_r.valid & run & mode_sub) begin
      data_r <= diff_w[15:0];
    end else if (wr & sel_data & clk_en_r) begin
      data_r <= bus_i.wdata[15:0];
    end
  end

  // request flag: set beats software write of 0
  // request pending
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      req_r <= 1'b0;
    end else if (raise_req) begin
      req_r <= 1'b1;
    end else if (wr & sel_req) begin
      req_r <= wd8[`DOU_GROUP_BIT];
    end
  end

  // mask and priority bits
  // priority bits
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mask_r <= `DOU_RST_MASK;
      prio_hi_r <= 1'b1;
      prio_lo_r <= 1'b1;
    end else begin
      if (wr & sel_mask) begin
        mask_r <= wd8[`DOU_GROUP_BIT];
      end
      if (wr & sel_phi) begin
        prio_hi_r <= wd8[`DOU_GROUP_BIT];
      end
      if (wr & sel_plo) begin
        prio_lo_r <= wd8[`DOU_GROUP_BIT];
      end
    end
  end

  // sticky event status, enable, write-one-to-clear; set wins
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stat_r <= 2'h0;
      stat_en_r <= 2'h0;
    end else begin
      stat_r <= event_w | (stat_r & ~((wr & sel_sclr) ? bus_i.wdata[1:0] : 2'h0));
      if (wr & sel_sen) begin
        stat_en_r <= bus_i.wdata[1:0];
      end
    end
  end

  // registered outputs
  // mask gate
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_r <= 32'h0;
      irq_r <= 1'b0;
      service_r <= 1'b0;
      prio_out_r <= `DOU_RST_PRIO;
    end else begin
      rdata_r <= bus_i.rd ? rd_mux : 32'h0;
      irq_r <= |(stat_r & stat_en_r);
      service_r <= req_r & ~mask_r;
      prio_out_r <= {prio_hi_r, prio_lo_r};
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o = irq_r;
  assign service_req_o = service_r;
  assign priority_o = prio_out_r;
endmodule
`default_nettype wire

// ---- sim/dou_bus_host.sv ----
// bus master model standing in for the processor core
`timescale 1ns/100ps
`default_nettype none
`include "dou_cfg.svh"
module dou_bus_host (
  input wire logic core_clk_i,
  input wire logic [31:0] rdata_i,
  output var dou_pkg::dou_bus_s bus_o
);
  import dou_pkg::*;
  initial bus_o = '0;
  // ====
  // one-cycle strobes; address and data scrambled when idle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    bus_o <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus_o <= '{addr: ~a, wdata: 32'hFFFFFFFF, wr: 1'b0, rd: 1'b0};
    @(negedge core_clk_i);
    d = rdata_i;
  endtask
  // mask, clear, priority, mode, load, clear flag, clear, unmask
  task automatic setup(input logic [7:0] ctl, input logic [15:0] v);
    wr_reg(`DOU_OFF_MASK, 32'h40);
    wr_reg(`DOU_OFF_REQ, 32'h0);
    wr_reg(`DOU_OFF_PRIO_HI, 32'h40);
    wr_reg(`DOU_OFF_PRIO_LO, 32'h40);
    wr_reg(`DOU_OFF_CTRL, {24'h0, ctl});
    wr_reg(`DOU_OFF_DATA, {16'h0, v});
    wr_reg(`DOU_OFF_CTRL, {24'h0, ctl | 8'h40});
    wr_reg(`DOU_OFF_REQ, 32'h0);
    wr_reg(`DOU_OFF_MASK, 32'h0);
  endtask
endmodule
`default_nettype wire

// ---- sim/dou_unit_chk.sv ----
// port checker for the data operation unit
`timescale 1ns/100ps
`default_nettype none
`include "dou_cfg.svh"
module dou_unit_chk (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire dou_pkg::dou_bus_s bus_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o,
  input wire logic service_req_o,
  input wire logic [1:0] priority_o
);
  import dou_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  wire logic wr = bus_i.wr;
  wire logic [7:0] a = bus_i.addr;
  wire logic d6 = bus_i.wdata[6];
  wire logic op = wr && a == `DOU_OFF_OPERAND;
  wire logic pw = wr && (a == `DOU_OFF_PRIO_HI || a == `DOU_OFF_PRIO_LO);
  wire logic ci = wr && a inside {`DOU_OFF_OPERAND, `DOU_OFF_REQ, `DOU_OFF_STAT_EN, `DOU_OFF_CTRL};
  wire logic cs = wr && a inside {`DOU_OFF_OPERAND, `DOU_OFF_REQ, `DOU_OFF_MASK, `DOU_OFF_CTRL};
  // ====
  // assertions
  a_mask_blocks: assert property (wr && a == `DOU_OFF_MASK && d6 |=> ##1 !service_req_o)
    else $error("mask did not block");
  a_req_clear: assert property (wr && a == `DOU_OFF_REQ && !d6 && !$past(op) |=> ##1 !service_req_o)
    else $error("request clear ignored");
  a_en_off: assert property (wr && a == `DOU_OFF_STAT_EN && bus_i.wdata[1:0] == 2'h0 |=> ##1 !irq_o)
    else $error("irq with enables off");
  a_irq_rise: assert property ($rose(irq_o) |-> $past(ci, 2) || $past(ci, 3))
    else $error("irq rose without cause");
  a_svc_rise: assert property ($rose(service_req_o) |-> $past(cs, 2) || $past(cs, 3))
    else $error("service rose without cause");
  a_prio_write: assert property (wr && a == `DOU_OFF_PRIO_HI |=> ##1 priority_o[1] == $past(d6, 2))
    else $error("priority high bit wrong");
  a_prio_hold: assert property (!$stable(priority_o) |-> $past(pw, 2))
    else $error("priority moved unasked");
  a_rdata_idle: assert property (!bus_i.rd |=> rdata_o == 32'h0)
    else $error("read data outside slot");
  c_irq: cover property ($rose(irq_o));
  c_svc: cover property ($rose(service_req_o));
  c_prio: cover property (pw);
endmodule
bind dou_unit dou_unit_chk i_dou_unit_chk (.core_clk_i, .reset_i, .bus_i, .rdata_o, .irq_o, .service_req_o,
  .priority_o);
`default_nettype wire

// ---- sim/test_dou_unit.sv ----
// self-checking bench for the data operation unit
`timescale 1ns/100ps
`default_nettype none
`include "dou_cfg.svh"
module test_dou_unit;
  import dou_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  dou_bus_s bus;
  logic [31:0] rdata;
  logic irq, svc;
  logic [1:0] prio;
  int err_count = 0;
  int checks_done = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  dou_bus_host i_dou_bus_host (.core_clk_i(core_clk_i), .rdata_i(rdata), .bus_o(bus));
  dou_unit i_dou_unit (.core_clk_i(core_clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata),
    .irq_o(irq), .service_req_o(svc), .priority_o(prio));
  // ====
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    i_dou_bus_host.wr_reg(a, d);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    i_dou_bus_host.rd_reg(a, d);
    chk(d, e);
  endtask
  task automatic settle;
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #50000;
    err_count++;
    finish_test;
  end
  // ====
  // tests
  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    r(`DOU_OFF_MASK, 32'h40);
    chk({30'h0, prio}, 32'h3);
    for (int i = 0; i < 4; i++) begin
      w(`DOU_OFF_PRIO_HI, {25'h0, i[1], 6'h0});
      w(`DOU_OFF_PRIO_LO, {25'h0, i[0], 6'h0});
      settle;
      chk({30'h0, prio}, 32'(i));
    end
    $display("priority test done");
    w(`DOU_OFF_PERIPH, 32'h1);
    i_dou_bus_host.setup(8'h11, 16'hFFFF);
    w(`DOU_OFF_STAT_EN, 32'h3);
    w(`DOU_OFF_OPERAND, 32'h2);
    settle;
    r(`DOU_OFF_DATA, 32'h1);
    r(`DOU_OFF_CTRL, 32'h31);
    r(`DOU_OFF_REQ, 32'h40);
    chk({31'h0, svc}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    r(`DOU_OFF_STATUS, 32'h3);
    w(`DOU_OFF_CTRL, 32'h11);
    r(`DOU_OFF_CTRL, 32'h31);
    w(`DOU_OFF_CTRL, 32'h51);
    r(`DOU_OFF_CTRL, 32'h11);
    w(`DOU_OFF_MASK, 32'h40);
    settle;
    chk({31'h0, svc}, 32'h0);
    w(`DOU_OFF_REQ, 32'h0);
    r(`DOU_OFF_REQ, 32'h0);
    w(`DOU_OFF_STAT_CLR, 32'h3);
    settle;
    chk({31'h0, irq}, 32'h0);
    $display("add test done");
    i_dou_bus_host.setup(8'h02, 16'h0001);
    w(`DOU_OFF_OPERAND, 32'h3);
    settle;
    r(`DOU_OFF_DATA, 32'hFFFE);
    r(`DOU_OFF_REQ, 32'h0);
    chk({31'h0, svc}, 32'h0);
    $display("subtract test done");
    i_dou_bus_host.setup(8'h10, 16'h0005);
    w(`DOU_OFF_OPERAND, 32'h5);
    settle;
    r(`DOU_OFF_CTRL, 32'h10);
    w(`DOU_OFF_OPERAND, 32'h7);
    settle;
    r(`DOU_OFF_CTRL, 32'h30);
    r(`DOU_OFF_DATA, 32'h5);
    w(`DOU_OFF_CTRL, 32'h13);
    r(`DOU_OFF_CTRL, 32'h30);
    w(`DOU_OFF_CTRL, 32'h54);
    r(`DOU_OFF_CTRL, 32'h14);
    w(`DOU_OFF_OPERAND, 32'h3);
    settle;
    r(`DOU_OFF_CTRL, 32'h14);
    w(`DOU_OFF_OPERAND, 32'h9);
    settle;
    r(`DOU_OFF_CTRL, 32'h34);
    w(`DOU_OFF_STAT_EN, 32'h0);
    settle;
    chk({31'h0, irq}, 32'h0);
    $display("compare test done");
    w(`DOU_OFF_PERIPH, 32'h3);
    r(`DOU_OFF_DATA, 32'h0);
    w(`DOU_OFF_PERIPH, 32'h0);
    w(`DOU_OFF_DATA, 32'h1234);
    w(`DOU_OFF_PERIPH, 32'h1);
    r(`DOU_OFF_DATA, 32'h0);
    w(8'h30, 32'hFF);
    r(8'h30, 32'h0);
    $display("peripheral test done");
    finish_test;
  end
endmodule
`default_nettype wire
